// >>> slbs_pkg.sv
// constants shared by the step-loss and border supervisor
package slbs_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_FRAME = 8'h00;   // frame byte push, write only
    localparam logic [7:0] OFF_STATUS = 8'h04;  // status, write one to clear
    localparam logic [7:0] OFF_SCALE = 8'h08;   // steps per turn and encoder counts
    localparam logic [7:0] OFF_CTP = 8'h0C;     // step-loss settings readback
    localparam logic [7:0] OFF_BORDER = 8'h10;  // border settings readback
    localparam logic [7:0] OFF_FILL = 8'h14;    // bytes received in current frame
    // status bit positions
    localparam int ST_ERR = 0;
    localparam int ST_ALARM = 1;
    localparam int ST_LEFT = 2;
    localparam int ST_RIGHT = 3;
    localparam int ST_FRAME_OK = 4;
    localparam int ST_FRAME_BAD = 5;
    // frame command codes and lengths
    localparam logic [31:0] CMD_STEP_LOSS = 32'h70746373;
    localparam logic [31:0] CMD_BORDER = 32'h73646573;
    localparam logic [4:0] LEN_STEP_LOSS = 5'h12;  // 18 bytes
    localparam logic [4:0] LEN_BORDER = 5'h1A;     // 26 bytes
    localparam logic [4:0] IDX_FIRST_FIELD = 5'h04;
    // step-loss flag byte bits
    localparam int SUPERVISION_ENABLE_BIT = 0;
    localparam int SUPERVISION_SOURCE_BIT = 1;
    localparam int ALARM_ON_MISMATCH_BIT = 2;
    localparam int TURN_SENSOR_INVERT_BIT = 3;
    localparam int SLIPPAGE_CORRECTION_BIT = 4;
    // border flag byte bits
    localparam int BORDER_SOURCE_BIT = 0;
    localparam int STOP_LEFT_BIT = 1;
    localparam int STOP_RIGHT_BIT = 2;
    localparam int MISSET_DETECTION_BIT = 3;
    // limit switch flag byte bits
    localparam int SWITCH_SWAP_BIT = 0;
    localparam int FIRST_SWITCH_LOW_ACTIVE_BIT = 1;
    localparam int SECOND_SWITCH_LOW_ACTIVE_BIT = 2;
    // fraction limit in 1/256 microsteps
    localparam logic signed [15:0] FRAC_LIMIT = 16'sh00FF;
    // values after reset
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [15:0] RST_STEPS_PER_TURN = 16'h00C8;
    localparam logic [15:0] RST_COUNTS_PER_TURN = 16'h0400;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> slbs_sync3.sv
// three-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module slbs_sync3 #(
    parameter int W = 1
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [W-1:0] PIN,
    output logic [W-1:0] LEVEL
);
    logic [W-1:0] s1_q; // first stage, read only by s2
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] agree; // bits where stages two and three agree
    assign agree = ~(s2_q ^ s3_q);
    assign LEVEL = level_q;
    // shift chain; level follows once stages two and three agree
    always_ff @(posedge CLK) begin
        if (RST) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_q <= '0;
        end else begin
            s1_q <= PIN;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= (agree & s3_q) | (~agree & level_q);
        end
    end
endmodule
`default_nettype wire

// >>> slbs_top.sv
// step-loss and border supervisor with axi4-lite register port
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - step-loss frame: code, threshold, flags, 18 bytes
// - supervision runs only while enable bit set
// - source bit picks turn sensor or encoder
// - alarm on mismatch when alarm bit set
// - turn sensor active low unless inverted
// - slippage correction, encoder only, not with alarm
// - enabling captures motor and encoder reference pair
// - each step converts encoder position to steps
// - error flag when difference exceeds threshold
// - threshold is unsigned 8-bit whole steps
// - turn sensor edge latches motor step count
// - each turn, mismatch reaching threshold flags error
// - border frame layout, 26 bytes in all
// - source bit picks programmed borders or switches
// - stop at left or right border per bits
// - misset bit stops motion at both borders
// - swap bit makes first switch the right one
// - per-switch bit makes low level active
// - border fraction in 1/256, clamped to 255
module slbs_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic STEP_STROBE,
    input wire logic [31:0] MOTOR_STEPS,
    input wire logic [7:0] MOTOR_FRAC,
    input wire logic [31:0] ENCODER_COUNT,
    input wire logic TURN_SENSOR_PIN,
    input wire logic FIRST_LIMIT_INPUT,
    input wire logic SECOND_LIMIT_INPUT,
    output logic STEP_LOSS_ERROR,
    output logic ALARM,
    output logic SLIP_CORRECT,
    output logic LEFT_BORDER_HIT,
    output logic RIGHT_BORDER_HIT,
    output logic STOP_LEFT,
    output logic STOP_RIGHT
);
    ////////////////////////////////////////////////////////////////////////
    // helper functions
    // sign-extend a 32-bit value to 64 bits
    function automatic logic signed [63:0] sx32(input logic [31:0] v);
        sx32 = {{32{v[31]}}, v};
    endfunction
    // magnitude of a signed 64-bit value
    function automatic logic [63:0] mag(input logic signed [63:0] v);
        mag = v[63] ? 64'(-v) : 64'(v);
    endfunction
    // whole plus clamped fraction as 1/256 microsteps
    function automatic logic signed [47:0] fix(input logic [31:0] w, input logic [15:0] f);
        logic signed [15:0] c;
        c = $signed(f);
        if (c > slbs_pkg::FRAC_LIMIT) begin
            c = slbs_pkg::FRAC_LIMIT;
        end else if (c < -slbs_pkg::FRAC_LIMIT) begin
            c = -slbs_pkg::FRAC_LIMIT;
        end
        fix = ($signed({{16{w[31]}}, w}) <<< 8) + 48'($signed(c));
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // state
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] awaddr_q;   // held write address
    logic [31:0] wdata_q;   // held write data
    logic [3:0] wstrb_q;
    logic [7:0] thr_q;      // step-loss threshold
    logic [7:0] ctp_flags_q;
    logic [7:0] bflags_q;   // border flag byte
    logic [7:0] sflags_q;   // limit switch flag byte
    logic [31:0] lw_q, rw_q; // border whole parts
    logic [15:0] lf_q, rf_q; // border fractions
    logic [15:0] spt_q, cpt_q; // steps per turn, encoder counts per turn
    logic [4:0] idx_q;      // byte index in frame
    logic [31:0] cmd_q;     // command code collector
    logic kind_q;           // 1: border frame
    logic [15:0] sum_q;     // running checksum
    logic [7:0] crc_lo_q;
    logic [7:0] s_b4_q, s_b5_q; // staged flag bytes
    logic [31:0] s_lw_q, s_rw_q;
    logic [15:0] s_lf_q, s_rf_q;
    logic ok_q, bad_q;      // sticky frame result flags
    logic err_q, alarm_q, corr_q, lhit_q, rhit_q, stopl_q, stopr_q;
    logic [31:0] ref_mot_q, ref_enc_q; // encoder reference pair
    logic [31:0] turn_ref_q; // step count at last sensor edge
    logic turn_valid_q;
    logic turn_prev_q;
    logic [2:0] pins;       // synchronised sensor and switches
    slbs_sync3 #(.W(3)) u_sync (
        .CLK(CLK),
        .RST(RST),
        .PIN({SECOND_LIMIT_INPUT, FIRST_LIMIT_INPUT, TURN_SENSOR_PIN}),
        .LEVEL(pins)
    );
    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire wr_go = !awready_q && !wready_q && !bvalid_q;
    wire rd_go = S_AXI_ARVALID && arready_q;
    wire wr_frame = wr_go && awaddr_q == slbs_pkg::OFF_FRAME && wstrb_q[0];
    wire wr_status = wr_go && awaddr_q == slbs_pkg::OFF_STATUS && wstrb_q[0];
    wire wr_scale = wr_go && awaddr_q == slbs_pkg::OFF_SCALE;
    wire wr_known = awaddr_q == slbs_pkg::OFF_FRAME || awaddr_q == slbs_pkg::OFF_STATUS
                    || awaddr_q == slbs_pkg::OFF_SCALE;
    wire [7:0] byte_in = wdata_q[7:0];
    wire [31:0] clr = wr_status ? wdata_q : 32'h0; // write-one-to-clear mask
    wire [31:0] scale_w = {cpt_q, spt_q};
    wire [31:0] scale_n = {wstrb_q[3] ? wdata_q[31:24] : scale_w[31:24],
                           wstrb_q[2] ? wdata_q[23:16] : scale_w[23:16],
                           wstrb_q[1] ? wdata_q[15:8] : scale_w[15:8],
                           wstrb_q[0] ? wdata_q[7:0] : scale_w[7:0]};
    wire [31:0] status = {26'h0, bad_q, ok_q, rhit_q, lhit_q, alarm_q, err_q};
    wire [31:0] rd_word = S_AXI_ARADDR == slbs_pkg::OFF_STATUS ? status
                        : S_AXI_ARADDR == slbs_pkg::OFF_SCALE ? scale_w
                        : S_AXI_ARADDR == slbs_pkg::OFF_CTP ? {16'h0, ctp_flags_q, thr_q}
                        : S_AXI_ARADDR == slbs_pkg::OFF_BORDER ? {16'h0, sflags_q, bflags_q}
                        : S_AXI_ARADDR == slbs_pkg::OFF_FILL ? {27'h0, idx_q} : 32'h0;
    wire rd_known = S_AXI_ARADDR == slbs_pkg::OFF_STATUS || S_AXI_ARADDR == slbs_pkg::OFF_SCALE
                    || S_AXI_ARADDR == slbs_pkg::OFF_CTP || S_AXI_ARADDR == slbs_pkg::OFF_BORDER
                    || S_AXI_ARADDR == slbs_pkg::OFF_FILL || S_AXI_ARADDR == slbs_pkg::OFF_FRAME;
    // write channels: take address and data in either order
    always_ff @(posedge CLK) begin
        if (RST) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= slbs_pkg::RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && awready_q) begin
                awaddr_q <= S_AXI_AWADDR;
                awready_q <= 1'b0;
            end
            if (S_AXI_WVALID && wready_q) begin
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
                wready_q <= 1'b0;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? slbs_pkg::RESP_OKAY : slbs_pkg::RESP_SLVERR;
            end else if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end
    // read channel: one-cycle answer
    always_ff @(posedge CLK) begin
        if (RST) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= slbs_pkg::RESP_OKAY;
        end else if (rd_go) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_known ? slbs_pkg::RESP_OKAY : slbs_pkg::RESP_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // frame receiver
    wire [31:0] cmd_n = {byte_in, cmd_q[31:8]};           // little-endian code
    wire code_ctp = cmd_n == slbs_pkg::CMD_STEP_LOSS;
    wire code_brd = cmd_n == slbs_pkg::CMD_BORDER;
    wire [4:0] flen = kind_q ? slbs_pkg::LEN_BORDER : slbs_pkg::LEN_STEP_LOSS;
    wire in_body = idx_q >= slbs_pkg::IDX_FIRST_FIELD && idx_q < flen - 5'h02;
    wire last_b = wr_frame && idx_q == flen - 5'h01;
    wire crc_ok = {byte_in, crc_lo_q} == sum_q;
    wire commit = last_b && crc_ok;
    wire ctp_commit = commit && !kind_q;
    wire brd_commit = commit && kind_q;
    // collect bytes into staging, apply only on a good checksum
    always_ff @(posedge CLK) begin
        if (RST) begin
            idx_q <= 5'h00;
            cmd_q <= 32'h0;
            kind_q <= 1'b0;
            sum_q <= 16'h0;
            crc_lo_q <= 8'h00;
            {s_b4_q, s_b5_q, s_lw_q, s_lf_q, s_rw_q, s_rf_q} <= '0;
        end else if (wr_frame) begin
            idx_q <= idx_q + 5'h01;
            if (idx_q < slbs_pkg::IDX_FIRST_FIELD) begin
                cmd_q <= cmd_n;
                sum_q <= 16'h0;
            end
            if (idx_q == 5'h03) begin
                kind_q <= code_brd;
                if (!code_ctp && !code_brd) begin
                    idx_q <= 5'h00; // unknown code, resync
                end
            end
            if (in_body) begin
                sum_q <= sum_q + {8'h00, byte_in}; // reserved bytes counted, not used
            end
            if (idx_q == flen - 5'h02) begin
                crc_lo_q <= byte_in;
            end
            if (last_b) begin
                idx_q <= 5'h00;
            end
            case (idx_q)
                5'h04: s_b4_q <= byte_in;
                5'h05: s_b5_q <= byte_in;
                5'h06: s_lw_q[7:0] <= byte_in;
                5'h07: s_lw_q[15:8] <= byte_in;
                5'h08: s_lw_q[23:16] <= byte_in;
                5'h09: s_lw_q[31:24] <= byte_in;
                5'h0A: s_lf_q[7:0] <= byte_in;
                5'h0B: s_lf_q[15:8] <= byte_in;
                5'h0C: s_rw_q[7:0] <= byte_in;
                5'h0D: s_rw_q[15:8] <= byte_in;
                5'h0E: s_rw_q[23:16] <= byte_in;
                5'h0F: s_rw_q[31:24] <= byte_in;
                5'h10: s_rf_q[7:0] <= byte_in;
                5'h11: s_rf_q[15:8] <= byte_in;
                default: ;
            endcase
        end
    end
    // settings registers, loaded from accepted frames or scale writes
    always_ff @(posedge CLK) begin
        if (RST) begin
            thr_q <= slbs_pkg::RST_FLAGS;
            ctp_flags_q <= slbs_pkg::RST_FLAGS;
            bflags_q <= slbs_pkg::RST_FLAGS;
            sflags_q <= slbs_pkg::RST_FLAGS;
            {lw_q, lf_q, rw_q, rf_q} <= '0;
            spt_q <= slbs_pkg::RST_STEPS_PER_TURN;
            cpt_q <= slbs_pkg::RST_COUNTS_PER_TURN;
        end else begin
            if (ctp_commit) begin
                thr_q <= s_b4_q;
                ctp_flags_q <= s_b5_q;
            end
            if (brd_commit) begin
                bflags_q <= s_b4_q;
                sflags_q <= s_b5_q;
                {lw_q, lf_q, rw_q, rf_q} <= {s_lw_q, s_lf_q, s_rw_q, s_rf_q};
            end
            if (wr_scale) begin
                {cpt_q, spt_q} <= scale_n;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // step-loss supervision
    wire sup_en = ctp_flags_q[slbs_pkg::SUPERVISION_ENABLE_BIT];
    wire use_turn = ctp_flags_q[slbs_pkg::SUPERVISION_SOURCE_BIT];
    wire alarm_en = ctp_flags_q[slbs_pkg::ALARM_ON_MISMATCH_BIT];
    wire corr_en = ctp_flags_q[slbs_pkg::SLIPPAGE_CORRECTION_BIT] && !use_turn && !alarm_en;
    wire turn_act = pins[0] ^ ~ctp_flags_q[slbs_pkg::TURN_SENSOR_INVERT_BIT];
    wire turn_edge = turn_act && !turn_prev_q;
    // encoder counts scaled to steps, compared without division
    wire signed [63:0] m_d = sx32(MOTOR_STEPS) - sx32(ref_mot_q);
    wire signed [63:0] e_d = sx32(ENCODER_COUNT) - sx32(ref_enc_q);
    wire signed [63:0] diff = e_d * $signed({48'h0, spt_q}) - m_d * $signed({48'h0, cpt_q});
    wire [63:0] lim = {56'h0, thr_q} * {48'h0, cpt_q};
    wire enc_miss = sup_en && !use_turn && STEP_STROBE && mag(diff) > lim;
    wire [63:0] turn_gap = mag(sx32(MOTOR_STEPS) - sx32(turn_ref_q) - $signed({48'h0, spt_q}));
    wire turn_miss = sup_en && use_turn && turn_edge && turn_valid_q
                     && turn_gap >= {56'h0, thr_q};
    wire miss_err = turn_miss || (enc_miss && !corr_en);
    wire rearm = ctp_commit || (enc_miss && corr_en);
    // reference pair and turn latch
    always_ff @(posedge CLK) begin
        if (RST) begin
            ref_mot_q <= 32'h0;
            ref_enc_q <= 32'h0;
            turn_ref_q <= 32'h0;
            turn_valid_q <= 1'b0;
            turn_prev_q <= 1'b1; // synced pins read 0 after reset: no false edge
        end else begin
            turn_prev_q <= turn_act;
            if (rearm) begin
                ref_mot_q <= MOTOR_STEPS;
                ref_enc_q <= ENCODER_COUNT;
            end
            if (ctp_commit || !sup_en || !use_turn) begin
                turn_valid_q <= 1'b0;
            end else if (turn_edge) begin
                turn_ref_q <= MOTOR_STEPS;
                turn_valid_q <= 1'b1;
            end
        end
    end
    // sticky error and alarm; a new mismatch wins over a clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            err_q <= 1'b0;
            alarm_q <= 1'b0;
            corr_q <= 1'b0;
            ok_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            err_q <= miss_err || (err_q && !clr[slbs_pkg::ST_ERR] && !ctp_commit);
            alarm_q <= (miss_err && alarm_en) || (alarm_q && !clr[slbs_pkg::ST_ALARM]);
            corr_q <= enc_miss && corr_en;
            ok_q <= commit || (ok_q && !clr[slbs_pkg::ST_FRAME_OK]);
            bad_q <= (last_b && !crc_ok) || (bad_q && !clr[slbs_pkg::ST_FRAME_BAD]);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // borders
    wire sw1 = pins[1] ^ sflags_q[slbs_pkg::FIRST_SWITCH_LOW_ACTIVE_BIT];
    wire sw2 = pins[2] ^ sflags_q[slbs_pkg::SECOND_SWITCH_LOW_ACTIVE_BIT];
    wire swap = sflags_q[slbs_pkg::SWITCH_SWAP_BIT];
    wire sw_left = swap ? sw2 : sw1;
    wire sw_right = swap ? sw1 : sw2;
    wire signed [47:0] pos = 48'($signed({MOTOR_STEPS, MOTOR_FRAC}));
    wire prog = bflags_q[slbs_pkg::BORDER_SOURCE_BIT];
    wire at_left = prog ? pos <= fix(lw_q, lf_q) : sw_left;
    wire at_right = prog ? pos >= fix(rw_q, rf_q) : sw_right;
    wire misset = bflags_q[slbs_pkg::MISSET_DETECTION_BIT];
    // border hits and stop requests
    always_ff @(posedge CLK) begin
        if (RST) begin
            lhit_q <= 1'b0;
            rhit_q <= 1'b0;
            stopl_q <= 1'b0;
            stopr_q <= 1'b0;
        end else begin
            lhit_q <= at_left;
            rhit_q <= at_right;
            stopl_q <= at_left && (bflags_q[slbs_pkg::STOP_LEFT_BIT] || misset);
            stopr_q <= at_right && (bflags_q[slbs_pkg::STOP_RIGHT_BIT] || misset);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign STEP_LOSS_ERROR = err_q;
    assign ALARM = alarm_q;
    assign SLIP_CORRECT = corr_q;
    assign LEFT_BORDER_HIT = lhit_q;
    assign RIGHT_BORDER_HIT = rhit_q;
    assign STOP_LEFT = stopl_q;
    assign STOP_RIGHT = stopr_q;
    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking dcb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_bad_end;
        last_b && !crc_ok ##1 1'b1;
    endsequence
    AST_ERR_NEEDS_ENABLE: assert property ($rose(err_q) |-> $past(sup_en))
        else $error("error flag rose while supervision off");
    AST_ALARM_CAUSE: assert property ($rose(alarm_q) |-> $past(alarm_en) && err_q)
        else $error("alarm rose without alarm bit or error");
    AST_ERR_STICKY: assert property (err_q && !clr[0] && !ctp_commit |=> err_q)
        else $error("error flag dropped without clear");
    AST_BAD_FRAME: assert property (s_bad_end |-> $stable(ctp_flags_q) && $stable(bflags_q))
        else $error("settings changed on bad checksum");
    AST_STOP_LEFT: assert property (at_left && bflags_q[1] |=> STOP_LEFT)
        else $error("no left stop at left border");
    AST_MISSET: assert property (at_right && misset |=> STOP_RIGHT)
        else $error("no right stop with misset detection");
    AST_TURN_LATCH: assert property (sup_en && use_turn && turn_edge && !ctp_commit
        |=> turn_ref_q == $past(MOTOR_STEPS) && turn_valid_q)
        else $error("turn edge did not latch step count");
    AST_CORR_MODE: assert property (SLIP_CORRECT |-> $past(!use_turn && !alarm_en) && !$rose(err_q))
        else $error("correction outside encoder mode");
    AST_WRITE_ANSWER: assert property (wr_go |=> S_AXI_BVALID ##0 !S_AXI_AWREADY)
        else $error("write not answered next cycle");
endmodule
`default_nettype wire

// >>> slbs_motor.sv
// motor and encoder model on the supervisor's far side
`timescale 1ns/1ps
`default_nettype none
module slbs_motor (
    input wire logic CLK,
    input wire logic RST,
    input wire logic STEP_REQ,
    input wire logic SLIP,
    output logic STEP_STROBE,
    output logic [31:0] MOTOR_STEPS,
    output logic [31:0] ENCODER_COUNT
);
    // one step per request, counts valid with the strobe; a slipping step leaves the encoder behind
    always_ff @(posedge CLK) begin
        if (RST) begin
            STEP_STROBE <= 1'h0;
            MOTOR_STEPS <= 32'h0;
            ENCODER_COUNT <= 32'h0;
        end else begin
            STEP_STROBE <= STEP_REQ;
            MOTOR_STEPS <= MOTOR_STEPS + {31'h0, STEP_REQ};
            ENCODER_COUNT <= ENCODER_COUNT + ((STEP_REQ && !SLIP) ? 32'h2 : 32'h0);
        end
    end
endmodule
`default_nettype wire

// >>> slbs_top_test.sv
// self-checking bench for the step-loss supervisor
`timescale 1ns/1ps
`default_nettype none
module slbs_top_test;
    logic CLK = 1'h0, RST = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0, sreq = 1'h0, slip = 1'h0;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wda = 32'h0, rdat, lf = 32'h53102660, ms, ec, br_d;
    logic [1:0] rsp, bresp, rresp;
    logic awr, wrdy, bv, arr, rv, stb, err, alm, scp, lh, rh, sl, sr;
    logic tsp = 1'h1;
    int n_errors = 0, n_tests = 0, rm, re, e, xe, xa, xc = 0, nc = 0;
    always #25 CLK = ~CLK;
    // count correction pulses
    always @(posedge CLK)
        if (scp) nc <= nc + 1;
    slbs_motor mot_u (.CLK(CLK), .RST(RST), .STEP_REQ(sreq), .SLIP(slip), .STEP_STROBE(stb), .MOTOR_STEPS(ms),
        .ENCODER_COUNT(ec));
    slbs_top dut_u (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wda), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(br_d), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .STEP_STROBE(stb),
        .MOTOR_STEPS(ms), .MOTOR_FRAC(8'h0), .ENCODER_COUNT(ec), .TURN_SENSOR_PIN(tsp), .FIRST_LIMIT_INPUT(1'h0),
        .SECOND_LIMIT_INPUT(1'h0), .STEP_LOSS_ERROR(err), .ALARM(alm), .SLIP_CORRECT(scp), .LEFT_BORDER_HIT(lh),
        .RIGHT_BORDER_HIT(rh), .STOP_LEFT(sl), .STOP_RIGHT(sr));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // axi write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wda <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        do begin
            @(posedge CLK);
            if (awr) awv <= 1'h0;
            if (wrdy) wv <= 1'h0;
        end while (!bv);
        rsp = bresp;
        bry <= 1'h0;
        @(posedge CLK);
    endtask
    // axi read: result taken at the edge that sees rvalid
    task automatic rd(input logic [7:0] a);
        ara <= a;
        arv <= 1'h1;
        rry <= 1'h1;
        do begin
            @(posedge CLK);
            if (arr) arv <= 1'h0;
        end while (!rv);
        rdat = br_d;
        rsp = rresp;
        rry <= 1'h0;
        @(posedge CLK);
    endtask
    // config frame, byte by byte: code, payload low byte first, checksum; bad flips bit 0 of the checksum low byte
    task automatic frame(input logic [31:0] c, input int n, input logic [159:0] p, input logic bad);
        logic [7:0] b;
        logic [15:0] s;
        s = 16'h0;
        for (int i = 0; i < n; i++) begin
            b = i < 4 ? c[8*i +: 8] : i < n - 2 ? p[8*i-32 +: 8] : i == n - 2 ? s[7:0] ^ {7'h0, bad} : s[15:8];
            if (i > 3 && i < n - 2) s = s + {8'h0, b};
            wr(slbs_pkg::OFF_FRAME, {24'h0, b});
        end
    endtask
    // one motor step with random slip, then let the flags settle
    task automatic step;
        lf = lfsr(lf);
        slip <= lf[0];
        sreq <= 1'h1;
        @(posedge CLK);
        sreq <= 1'h0;
        repeat (4) @(posedge CLK);
    endtask
    initial begin
        repeat (20000) @(posedge CLK);
        n_errors++;
        finish_test();
    end
    // main sequence: reset values, unmapped access, flag modes under random slip, bad checksum
    initial begin
        logic [39:0] tbl;
        tbl = 40'h1115000501;
        repeat (12) @(posedge CLK);
        RST <= 1'h0;
        @(posedge CLK);
        rd(slbs_pkg::OFF_SCALE);
        chk(rdat, 32'h040000C8);
        rd(8'h20);
        chk({30'h0, rsp}, {30'h0, slbs_pkg::RESP_SLVERR});
        wr(slbs_pkg::OFF_SCALE, 32'h019000C8);
        for (int k = 0; k < 5; k++) begin
            wr(slbs_pkg::OFF_STATUS, 32'h3F);
            frame(slbs_pkg::CMD_STEP_LOSS, 18, {64'h0, {10{8'hA5}}, tbl[8*k +: 8], 8'h02}, 1'h0);
            rm = ms;
            re = ec;
            xe = 0;
            xa = 0;
            rd(slbs_pkg::OFF_CTP);
            chk(rdat, {16'h0, tbl[8*k +: 8], 8'h02});
            rd(slbs_pkg::OFF_STATUS);
            chk({30'h0, rdat[5:4]}, 32'h1);
            repeat (10) begin
                step();
                e = (ec - re) * 200 - (ms - rm) * 400;
                if (tbl[8*k] && (e > 800 || -e > 800)) begin
                    // correction only without the alarm bit: re-base, no error
                    if (tbl[8*k+4] && !tbl[8*k+2]) begin
                        xc++;
                        rm = ms;
                        re = ec;
                    end else begin
                        xe = 1;
                        xa = xa | tbl[8*k+2];
                    end
                end
                chk({31'h0, err}, xe);
                chk({31'h0, alm}, xa);
                chk(nc, xc);
            end
        end
        wr(slbs_pkg::OFF_STATUS, 32'h3F);
        frame(slbs_pkg::CMD_STEP_LOSS, 18, {144'h0, 8'h01, 8'h02}, 1'h1);
        rd(slbs_pkg::OFF_CTP);
        chk(rdat, 32'h1102);
        rd(slbs_pkg::OFF_STATUS);
        chk({30'h0, rdat[5:4]}, 32'h2);
        // turn sensor mode: four steps a turn, each turn one step longer
        wr(slbs_pkg::OFF_SCALE, 32'h01900004);
        frame(slbs_pkg::CMD_STEP_LOSS, 18, {144'h0, 8'h03, 8'h02}, 1'h0);
        for (int t = 0; t < 4; t++) begin
            repeat (4 + t) step();
            tsp <= 1'h0;
            repeat (8) @(posedge CLK);
            tsp <= 1'h1;
            repeat (8) @(posedge CLK);
            chk({31'h0, err}, {31'h0, t > 1});
        end
        // programmed borders just around the position, clamped fractions, then swapped switches
        for (int j = 0; j < 3; j++) begin
            frame(slbs_pkg::CMD_BORDER, 26, {48'hA5A5A5A5A5A5, 16'h0101, ms - 32'h1, 16'hFEFF, ms + 32'h1,
                j == 2 ? 8'h03 : 8'h00, j == 0 ? 8'h03 : j == 1 ? 8'h09 : 8'h00}, 1'h0);
            chk({30'h0, rh, lh}, {30'h0, 1'h1, j < 2});
            chk({30'h0, sr, sl}, {30'h0, j == 1, j < 2});
        end
        finish_test();
    end
endmodule
`default_nettype wire
